// *** inc/sbaen_pkg.sv ***
/*
  Package for the sideband event-enable and query command handler:
  command codes, register offsets, reset values, field layouts and carriers.
  Assumes an upstream parser that has already checked checksum and identifiers.
*/
// Behaviour
// - Pending-request event carries event type code 0x71.
// - Handle event-enable command 0x55, switching transport events on or off.
// - Store requester tag from enable command; put it in every later event.
// - Enable bit 0 is stored only; no medium-change event 0x70 is ever raised.
// - Enable bit 1 gates pending-request event; sent only while it is set.
// - Enable field is low 16 bits of bytes 16-19; bits 2-15 reserved.
// - Every error-free enable command is answered with code 0xD5.
// - Raise pending-request event for new commands not flagged in 0xD7 reply.
// - No pending-request event from query 0x56 until its 0xD7 reply is sent.
// - Event payload word holds type in low byte, upper bytes reserved.
// - Address query targets one channel; payload is checksum then padding.
// - Error-free address query is always accepted; answered only if chan_match is set.
// - Address count sits in top byte of response word at bytes 20-23.
// - Three reserved bytes beside the count are driven zero.
// - Each address packed as six bytes, byte 5 first, no gaps.
// - Odd address count appends two zero pad bytes; even count appends none.
// - Package identifier query 0x52 targets whole package, not a channel.
// - Reply flags bit 0 reports more pending commands; bits 7-1 read zero.
package sbaen_pkg;

  // ----------------------------------------------------------------------
  // Command and response codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_EVT_ENABLE = 8'h55;
  localparam logic [7:0] CMD_PEND_QUERY = 8'h56;
  localparam logic [7:0] CMD_PEND_REPLY = 8'h57;
  localparam logic [7:0] CMD_MAC_QUERY = 8'h58;
  localparam logic [7:0] CMD_PKG_ID = 8'h52;
  localparam logic [7:0] RSP_FLAG = 8'h80;
  localparam logic [7:0] RSP_EVT_ENABLE = 8'hd5;
  localparam logic [7:0] RSP_PEND_REPLY = 8'hd7;
  localparam logic [7:0] EVT_MEDIUM = 8'h70;
  localparam logic [7:0] EVT_PEND_REQ = 8'h71;
  localparam int EN_MEDIUM_BIT = 0;
  localparam int EN_PEND_BIT = 1;
  localparam int EN_W = 2;
  localparam int MAC_BYTES = 6;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_NOTICE_STATE = 8'h00;
  localparam logic [7:0] OFS_PLDM_CTRL = 8'h04;
  localparam logic [7:0] OFS_MAC_COUNT = 8'h08;
  localparam logic [7:0] OFS_PKG_ID0 = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;
  localparam logic [7:0] OFS_MAC_BASE = 8'h40;
  localparam int PLDM_POST_BIT = 0;
  localparam int PLDM_MORE_BIT = 1;
  localparam int IRQ_W = 3;
  localparam int IRQ_ENABLE_CMD = 0;
  localparam int IRQ_EVT_SENT = 1;
  localparam int IRQ_QUERY = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [EN_W-1:0] EN_RESET = '0;
  localparam logic [7:0] TAG_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctype;
    logic [7:0] tag;
    logic [31:0] arg;
    logic chan_match;
  } sbaen_cmd_s;

  typedef struct packed {
    logic [7:0] code;
    logic [31:0] data;
    logic has_data;
    logic last;
  } sbaen_rsp_s;

  typedef struct packed {
    logic [7:0] atype;
    logic [7:0] tag;
  } sbaen_evt_s;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RESP = 1'b1
  } sbaen_state_e;

endpackage : sbaen_pkg

// *** rtl/sbaen_core.sv ***
/*
  Sideband command handler: event enable, pending-request event with
  suppression, address query and package identifier query, APB registers.
  Assumes commands arrive checked and decoded from the parser on pclk and
  that responses and events are framed and checksummed downstream.
*/
`timescale 1ns/10ps
module sbaen_core #(
  parameter int MAX_ADDR = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sbaen_pkg::sbaen_cmd_s cmd,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output sbaen_pkg::sbaen_rsp_s rsp,
  output logic evt_valid,
  input wire logic evt_ready,
  output sbaen_pkg::sbaen_evt_s evt,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (MAX_ADDR < 1 || MAX_ADDR > 8)
  begin : g_bad_max
    $error("MAX_ADDR must lie between 1 and 8");
  end

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [5:0] resp_beats(input logic [7:0] code, input logic [7:0] cnt);
    logic [5:0] n;
    n = 6'd1;
    if (code == (sbaen_pkg::CMD_MAC_QUERY | sbaen_pkg::RSP_FLAG))
    begin
      n = 6'(6'd2 + ((6'(cnt) * 6'd6 + 6'd3) >> 2));
    end
    else if (code == (sbaen_pkg::CMD_PKG_ID | sbaen_pkg::RSP_FLAG))
    begin
      n = 6'd5;
    end
    else if (code == sbaen_pkg::RSP_PEND_REPLY)
    begin
      n = 6'd2;
    end
    return n;
  endfunction : resp_beats

  function automatic logic [7:0] mac_byte(input logic [MAX_ADDR*48-1:0] tbl,
                                          input logic [7:0] cnt, input logic [6:0] k);
    logic [6:0] idx;
    logic [6:0] j;
    logic [7:0] b;
    idx = k / 7'd6;
    j = 7'd5 - (k % 7'd6);
    b = 8'h00;
    for (int i = 0; i < MAX_ADDR; i++)
    begin
      if (idx == 7'(i) && idx < 7'(cnt))
      begin
        b = tbl[i*48 + 8*int'(j) +: 8];
      end
    end
    return b;
  endfunction : mac_byte

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  sbaen_pkg::sbaen_state_e st_q, st_d;
  logic [sbaen_pkg::EN_W-1:0] en_q, en_d;
  logic [7:0] tag_q, tag_d;
  logic supp_q, supp_d;
  logic pend_q, pend_d;
  logic more_q, more_d;
  logic [7:0] cnt_q, cnt_d;
  logic [31:0] pkg_id_q [4];
  logic [31:0] pkg_id_d [4];
  logic [47:0] mac_q [MAX_ADDR];
  logic [47:0] mac_d [MAX_ADDR];
  logic [MAX_ADDR*48-1:0] mac_flat;
  logic [sbaen_pkg::IRQ_W-1:0] sts_q, sts_d, irq_en_q, irq_en_d, ev;
  logic [5:0] beat_q, beat_d, nbeat_q, nbeat_d;
  sbaen_pkg::sbaen_rsp_s rsp_q, rsp_d;
  logic [31:0] prdata_q, prdata_d;
  logic cmd_take, rsp_take, reply_done, post_new, apb_wr, mapped;
  logic [31:0] rd_word;

  always_comb
  begin
    for (int i = 0; i < MAX_ADDR; i++)
    begin
      mac_flat[i*48 +: 48] = mac_q[i];
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  assign apb_wr = psel && penable && pwrite && pready;
  assign pready = psel && penable;
  assign prdata = prdata_q;
  assign pslverr = pready && !mapped;
  assign post_new = apb_wr && paddr == sbaen_pkg::OFS_PLDM_CTRL && pwdata[sbaen_pkg::PLDM_POST_BIT];

  always_comb
  begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      sbaen_pkg::OFS_NOTICE_STATE: rd_word = {16'h0000, tag_q, 4'h0, pend_q, supp_q, en_q};
      sbaen_pkg::OFS_PLDM_CTRL: rd_word = {30'h0000_0000, more_q, 1'b0};
      sbaen_pkg::OFS_MAC_COUNT: rd_word = {24'h00_0000, cnt_q};
      sbaen_pkg::OFS_IRQ_STATUS: rd_word = {29'h0000_0000, sts_q};
      sbaen_pkg::OFS_IRQ_CLEAR: rd_word = 32'h0000_0000;
      sbaen_pkg::OFS_IRQ_ENABLE: rd_word = {29'h0000_0000, irq_en_q};
      default:
      begin
        mapped = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
          if (paddr == 8'(sbaen_pkg::OFS_PKG_ID0 + 8'(4 * i)))
          begin
            mapped = 1'b1;
            rd_word = pkg_id_q[i];
          end
        end
        for (int i = 0; i < MAX_ADDR; i++)
        begin
          if (paddr == 8'(sbaen_pkg::OFS_MAC_BASE + 8'(8 * i)))
          begin
            mapped = 1'b1;
            rd_word = mac_q[i][31:0];
          end
          if (paddr == 8'(sbaen_pkg::OFS_MAC_BASE + 8'(8 * i + 4)))
          begin
            mapped = 1'b1;
            rd_word = {16'h0000, mac_q[i][47:32]};
          end
        end
      end
    endcase
  end

  always_comb
  begin
    prdata_d = prdata_q;
    more_d = more_q;
    cnt_d = cnt_q;
    irq_en_d = irq_en_q;
    pkg_id_d = pkg_id_q;
    mac_d = mac_q;
    if (psel && !penable && !pwrite)
    begin
      prdata_d = rd_word;
    end
    if (apb_wr)
    begin
      if (paddr == sbaen_pkg::OFS_PLDM_CTRL)
      begin
        more_d = pwdata[sbaen_pkg::PLDM_MORE_BIT];
      end
      if (paddr == sbaen_pkg::OFS_MAC_COUNT)
      begin
        cnt_d = (pwdata[7:0] > 8'(MAX_ADDR)) ? 8'(MAX_ADDR) : pwdata[7:0];
      end
      if (paddr == sbaen_pkg::OFS_IRQ_ENABLE)
      begin
        irq_en_d = pwdata[sbaen_pkg::IRQ_W-1:0];
      end
      for (int i = 0; i < 4; i++)
      begin
        if (paddr == 8'(sbaen_pkg::OFS_PKG_ID0 + 8'(4 * i)))
        begin
          pkg_id_d[i] = pwdata;
        end
      end
      for (int i = 0; i < MAX_ADDR; i++)
      begin
        if (paddr == 8'(sbaen_pkg::OFS_MAC_BASE + 8'(8 * i)))
        begin
          mac_d[i][31:0] = pwdata;
        end
        if (paddr == 8'(sbaen_pkg::OFS_MAC_BASE + 8'(8 * i + 4)))
        begin
          mac_d[i][47:32] = pwdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= sbaen_pkg::WORD_RESET;
      more_q <= 1'b0;
      cnt_q <= sbaen_pkg::COUNT_RESET;
      irq_en_q <= '0;
      for (int i = 0; i < 4; i++)
      begin
        pkg_id_q[i] <= sbaen_pkg::WORD_RESET;
      end
      for (int i = 0; i < MAX_ADDR; i++)
      begin
        mac_q[i] <= 48'h0000_0000_0000;
      end
    end
    else
    begin
      prdata_q <= prdata_d;
      more_q <= more_d;
      cnt_q <= cnt_d;
      irq_en_q <= irq_en_d;
      pkg_id_q <= pkg_id_d;
      mac_q <= mac_d;
    end
  end

  // ----------------------------------------------------------------------
  // Command engine and response beats
  // ----------------------------------------------------------------------
  assign cmd_ready = (st_q == sbaen_pkg::ST_IDLE);
  assign cmd_take = cmd_valid && cmd_ready;
  assign rsp_valid = (st_q == sbaen_pkg::ST_RESP);
  assign rsp_take = rsp_valid && rsp_ready;
  assign rsp = rsp_q;
  assign reply_done = rsp_take && rsp_q.last && rsp_q.code == sbaen_pkg::RSP_PEND_REPLY;

  function automatic sbaen_pkg::sbaen_rsp_s beat_of(input logic [7:0] code,
                                                    input logic [5:0] b, input logic [5:0] n);
    sbaen_pkg::sbaen_rsp_s r;
    logic [6:0] k;
    r.code = code;
    r.data = 32'h0000_0000;
    r.has_data = (code != sbaen_pkg::RSP_EVT_ENABLE);
    r.last = (b == n - 6'd1);
    k = 7'(4 * (int'(b) - 2));
    if (b == 6'd1 && code == (sbaen_pkg::CMD_MAC_QUERY | sbaen_pkg::RSP_FLAG))
    begin
      r.data = {cnt_q, 24'h00_0000};
    end
    else if (b >= 6'd2 && code == (sbaen_pkg::CMD_MAC_QUERY | sbaen_pkg::RSP_FLAG))
    begin
      r.data = {mac_byte(mac_flat, cnt_q, k), mac_byte(mac_flat, cnt_q, k + 7'd1),
                mac_byte(mac_flat, cnt_q, k + 7'd2), mac_byte(mac_flat, cnt_q, k + 7'd3)};
    end
    else if (b >= 6'd1 && code == (sbaen_pkg::CMD_PKG_ID | sbaen_pkg::RSP_FLAG))
    begin
      r.data = pkg_id_q[b[1:0] - 2'd1];
    end
    else if (b == 6'd1 && code == sbaen_pkg::RSP_PEND_REPLY)
    begin
      r.data = {31'h0000_0000, more_q};
    end
    return r;
  endfunction : beat_of

  always_comb
  begin
    logic [7:0] code;
    code = cmd.ctype | sbaen_pkg::RSP_FLAG;
    st_d = st_q;
    beat_d = beat_q;
    nbeat_d = nbeat_q;
    rsp_d = rsp_q;
    en_d = en_q;
    tag_d = tag_q;
    unique case (st_q)
      sbaen_pkg::ST_IDLE:
      begin
        if (cmd_take)
        begin
          if (cmd.ctype == sbaen_pkg::CMD_EVT_ENABLE)
          begin
            en_d = cmd.arg[sbaen_pkg::EN_W-1:0];
            tag_d = cmd.tag;
          end
          if (cmd.ctype == sbaen_pkg::CMD_EVT_ENABLE || cmd.ctype == sbaen_pkg::CMD_PEND_QUERY
              || cmd.ctype == sbaen_pkg::CMD_PEND_REPLY || cmd.ctype == sbaen_pkg::CMD_PKG_ID
              || (cmd.ctype == sbaen_pkg::CMD_MAC_QUERY && cmd.chan_match))
          begin
            st_d = sbaen_pkg::ST_RESP;
            beat_d = 6'd0;
            nbeat_d = resp_beats(code, cnt_q);
            rsp_d = beat_of(code, 6'd0, resp_beats(code, cnt_q));
          end
        end
      end
      sbaen_pkg::ST_RESP:
      begin
        if (rsp_take)
        begin
          if (rsp_q.last)
          begin
            st_d = sbaen_pkg::ST_IDLE;
          end
          else
          begin
            beat_d = beat_q + 6'd1;
            rsp_d = beat_of(rsp_q.code, beat_q + 6'd1, nbeat_q);
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= sbaen_pkg::ST_IDLE;
      beat_q <= 6'd0;
      nbeat_q <= 6'd0;
      rsp_q <= '0;
      en_q <= sbaen_pkg::EN_RESET;
      tag_q <= sbaen_pkg::TAG_RESET;
    end
    else
    begin
      st_q <= st_d;
      beat_q <= beat_d;
      nbeat_q <= nbeat_d;
      rsp_q <= rsp_d;
      en_q <= en_d;
      tag_q <= tag_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pending-request event and suppression
  // ----------------------------------------------------------------------
  assign evt_valid = pend_q && en_q[sbaen_pkg::EN_PEND_BIT] && !supp_q;
  assign evt = '{atype: sbaen_pkg::EVT_PEND_REQ, tag: tag_q};

  always_comb
  begin
    supp_d = supp_q;
    pend_d = pend_q;
    if (reply_done)
    begin
      supp_d = 1'b0;
      if (rsp_q.data[0])
      begin
        pend_d = 1'b0;
      end
    end
    if (cmd_take && cmd.ctype == sbaen_pkg::CMD_PEND_QUERY)
    begin
      supp_d = 1'b1;
    end
    if (evt_valid && evt_ready)
    begin
      pend_d = 1'b0;
    end
    if (post_new)
    begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      supp_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      supp_q <= supp_d;
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  always_comb
  begin
    ev = '0;
    ev[sbaen_pkg::IRQ_ENABLE_CMD] = cmd_take && cmd.ctype == sbaen_pkg::CMD_EVT_ENABLE;
    ev[sbaen_pkg::IRQ_EVT_SENT] = evt_valid && evt_ready;
    ev[sbaen_pkg::IRQ_QUERY] = cmd_take && cmd.ctype == sbaen_pkg::CMD_PEND_QUERY;
    sts_d = sts_q;
    if (apb_wr && paddr == sbaen_pkg::OFS_IRQ_CLEAR)
    begin
      sts_d = sts_q & ~pwdata[sbaen_pkg::IRQ_W-1:0];
    end
    sts_d = sts_d | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sts_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      sts_q <= sts_d;
      irq <= |(sts_d & irq_en_d);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_enable_taken;
    cmd_take && cmd.ctype == sbaen_pkg::CMD_EVT_ENABLE;
  endsequence

  sequence s_enable_answered;
    rsp_valid && rsp.code == sbaen_pkg::RSP_EVT_ENABLE && rsp.last && !rsp.has_data;
  endsequence

  a_evt_type_code: assert property (@(posedge pclk) disable iff (!presetn)
    evt_valid |-> evt.atype == 8'h71)
    else $error("event type code wrong");

  a_enable_tag_copy: assert property (@(posedge pclk) disable iff (!presetn)
    s_enable_taken |=> tag_q == $past(cmd.tag) && evt.tag == $past(cmd.tag))
    else $error("requester tag not stored");

  a_enable_bits_load: assert property (@(posedge pclk) disable iff (!presetn)
    s_enable_taken |=> en_q == $past(cmd.arg[1:0]))
    else $error("enable bits not loaded");

  a_evt_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    evt_valid |-> en_q[1])
    else $error("event sent while disabled");

  a_enable_response: assert property (@(posedge pclk) disable iff (!presetn)
    s_enable_taken |=> s_enable_answered)
    else $error("enable command not answered");

  a_query_suppress: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_take && cmd.ctype == sbaen_pkg::CMD_PEND_QUERY) |=> supp_q && !evt_valid
      until_with reply_done)
    else $error("event not suppressed after query");

  a_count_word: assert property (@(posedge pclk) disable iff (!presetn)
    (rsp_valid && rsp.code == 8'hd8 && beat_q == 6'd1) |-> rsp.data == {cnt_q, 24'h00_0000})
    else $error("address count word wrong");

  a_odd_pad_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rsp_valid && rsp.code == 8'hd8 && rsp.last && beat_q > 6'd1 && cnt_q[0])
      |-> rsp.data[15:0] == 16'h0000)
    else $error("pad bytes not zero");

  a_reply_flags: assert property (@(posedge pclk) disable iff (!presetn)
    (rsp_valid && rsp.code == 8'hd7 && beat_q == 6'd1) |-> rsp.data == {31'h0, more_q})
    else $error("reply flags wrong");

endmodule : sbaen_core

// *** verification/sbaen_mc_model.sv ***
/*
  Management controller model: issues checked commands, collects the
  response beats and accepts events.
  Assumes the handler runs on pclk; the bench calls send between edges.
*/
`timescale 1ns/10ps
module sbaen_mgmt_model (
  input wire logic pclk,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output sbaen_pkg::sbaen_cmd_s cmd,
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire sbaen_pkg::sbaen_rsp_s rsp,
  input wire logic evt_valid,
  output logic evt_ready,
  input wire sbaen_pkg::sbaen_evt_s evt
);
  logic [31:0] beat_q[$];
  logic [7:0] code_q;
  logic hd_q;
  logic stall = 1'h0;
  int n_evt = 0;
  sbaen_pkg::sbaen_evt_s evt_q;

  initial
  begin
    cmd_valid = 1'h0;
    cmd = '0;
    rsp_ready = 1'h0;
    evt_ready = 1'h1;
  end

  // --------------------------------------------------------------------
  // Event intake
  // --------------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (evt_valid && evt_ready)
    begin
      n_evt++;
      evt_q = evt;
    end
  end

  // --------------------------------------------------------------------
  // Command issue and response collection
  // --------------------------------------------------------------------
  task automatic send(input logic [7:0] ct, input logic [7:0] tg, input logic [31:0] a,
                      input logic ch);
    int w;
    beat_q.delete();
    @(posedge pclk);
    cmd_valid <= 1'h1;
    cmd <= '{ctype: ct, tag: tg, arg: a, chan_match: ch};
    do @(posedge pclk); while (cmd_ready !== 1'h1);
    cmd_valid <= 1'h0;
    cmd <= ~{ct, tg, a, ch};
    for (w = 0; w < 40; w++)
    begin
      rsp_ready <= !stall || w[0];
      @(posedge pclk);
      if (rsp_valid && rsp_ready)
      begin
        if (beat_q.size() == 0) hd_q = rsp.has_data;
        beat_q.push_back(rsp.data);
        code_q = rsp.code;
        if (rsp.last) break;
      end
    end
    rsp_ready <= 1'h0;
  endtask : send
endmodule : sbaen_mgmt_model

// *** verification/tb_sbaen_core.sv ***
/*
  Testbench for the sideband command handler: APB master tasks and
  command sequences through the controller model.
  Assumes the package, the core and the model are compiled before it.
*/
`timescale 1ns/10ps
module tb_sbaen_core;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic evt_valid, evt_ready, irq;
  sbaen_pkg::sbaen_cmd_s cmd;
  sbaen_pkg::sbaen_rsp_s rsp;
  sbaen_pkg::sbaen_evt_s evt;
  logic [7:0] mb[$];
  int num_errors = 0;
  int n_compared = 0;

  always #5 pclk = ~pclk;

  sbaen_core #(.MAX_ADDR(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
    .evt_valid(evt_valid), .evt_ready(evt_ready), .evt(evt), .irq(irq));

  sbaen_mgmt_model mgmt_u (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
    .evt_valid(evt_valid), .evt_ready(evt_ready), .evt(evt));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  function automatic logic [7:0] mbyte(input int i, input int j);
    return {4'(i + 1), 4'(j)};
  endfunction : mbyte

  task automatic reply(input logic more);
    int n0;
    apb(1'h1, sbaen_pkg::OFS_PLDM_CTRL, {30'h0, more, 1'h0});
    mgmt_u.send(sbaen_pkg::CMD_PEND_QUERY, 8'ha5, 32'h0, 1'h1);
    n0 = mgmt_u.n_evt;
    apb(1'h1, sbaen_pkg::OFS_PLDM_CTRL, {30'h0, more, 1'h1});
    repeat (4) @(posedge pclk);
    chk(mgmt_u.n_evt, n0);
    mgmt_u.send(sbaen_pkg::CMD_PEND_REPLY, 8'ha5, 32'h0, 1'h1);
    chk(32'(mgmt_u.code_q), 32'(sbaen_pkg::RSP_PEND_REPLY));
    chk(mgmt_u.beat_q[1], {31'h0, more});
    repeat (4) @(posedge pclk);
    chk(mgmt_u.n_evt, n0 + 32'(!more));
  endtask : reply

  task automatic mac(input int c);
    int i;
    int j;
    mb.delete();
    for (i = 0; i < c; i++)
      for (j = 5; j >= 0; j--)
        mb.push_back(mbyte(i, j));
    repeat (2 * (c % 2)) mb.push_back(8'h00);
    apb(1'h1, sbaen_pkg::OFS_MAC_COUNT, 32'(c));
    mgmt_u.send(sbaen_pkg::CMD_MAC_QUERY, 8'h00, 32'h0, 1'h1);
    chk(mgmt_u.beat_q.size(), 2 + mb.size() / 4);
    chk(mgmt_u.beat_q[0], 32'h0);
    chk(mgmt_u.beat_q[1], {8'(c), 24'h0});
    for (i = 0; i < mb.size() / 4; i++)
      chk(mgmt_u.beat_q[i + 2], {mb[4*i], mb[4*i+1], mb[4*i+2], mb[4*i+3]});
  endtask : mac

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, sbaen_pkg::OFS_NOTICE_STATE, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'h1, sbaen_pkg::OFS_IRQ_ENABLE, 32'h7);
    apb(1'h1, sbaen_pkg::OFS_PLDM_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    chk(mgmt_u.n_evt, 0);
    mgmt_u.send(sbaen_pkg::CMD_EVT_ENABLE, 8'h3c, 32'h0000_0006, 1'h1);
    chk(32'(mgmt_u.code_q), 32'(sbaen_pkg::RSP_EVT_ENABLE));
    chk(mgmt_u.beat_q.size(), 1);
    chk(32'(mgmt_u.hd_q), 32'h0);
    repeat (3) @(posedge pclk);
    chk(mgmt_u.n_evt, 1);
    chk(32'(mgmt_u.evt_q), 32'({sbaen_pkg::EVT_PEND_REQ, 8'h3c}));
    chk(32'(irq), 32'h1);
    apb(1'h0, sbaen_pkg::OFS_NOTICE_STATE, 32'h0);
    chk(rd, 32'h0000_3c02);
    apb(1'h0, sbaen_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h3);
    apb(1'h1, sbaen_pkg::OFS_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'h1, sbaen_pkg::OFS_IRQ_CLEAR, 32'h7);
    apb(1'h0, sbaen_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0);
    mgmt_u.send(sbaen_pkg::CMD_EVT_ENABLE, 8'h5a, 32'h1, 1'h1);
    apb(1'h0, sbaen_pkg::OFS_NOTICE_STATE, 32'h0);
    chk(rd, 32'h0000_5a01);
    apb(1'h1, sbaen_pkg::OFS_PLDM_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    chk(mgmt_u.n_evt, 1);
    mgmt_u.send(sbaen_pkg::CMD_EVT_ENABLE, 8'ha5, 32'h2, 1'h1);
    repeat (3) @(posedge pclk);
    chk(mgmt_u.n_evt, 2);
    chk(32'(mgmt_u.evt_q), 32'({sbaen_pkg::EVT_PEND_REQ, 8'ha5}));
    reply(1'h0);
    reply(1'h1);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, sbaen_pkg::OFS_MAC_BASE + 8'(8 * i),
          {mbyte(i, 3), mbyte(i, 2), mbyte(i, 1), mbyte(i, 0)});
      apb(1'h1, sbaen_pkg::OFS_MAC_BASE + 8'(8 * i + 4), {16'h0, mbyte(i, 5), mbyte(i, 4)});
    end
    mgmt_u.stall = 1'h1;
    for (int c = 1; c < 5; c++) mac(c);
    mgmt_u.send(sbaen_pkg::CMD_MAC_QUERY, 8'h00, 32'h0, 1'h0);
    chk(mgmt_u.beat_q.size(), 0);
    for (int i = 0; i < 4; i++)
      apb(1'h1, sbaen_pkg::OFS_PKG_ID0 + 8'(4 * i), {24'h5a_c3e1, 8'(i)});
    mgmt_u.send(sbaen_pkg::CMD_PKG_ID, 8'h00, 32'h0, 1'h0);
    chk(mgmt_u.beat_q.size(), 5);
    chk(32'(mgmt_u.code_q), 32'(sbaen_pkg::RSP_FLAG | sbaen_pkg::CMD_PKG_ID));
    for (int i = 0; i < 4; i++)
      chk(mgmt_u.beat_q[i + 1], {24'h5a_c3e1, 8'(i)});
    apb(1'h0, 8'hfc, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    end_of_test();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_of_test();
  end
endmodule : tb_sbaen_core
